// ### core/apv_pkg.sv
// Purpose: constants for the audio power and volume control block
// Assumes: 16-bit registers at word addresses 4 and 5 of the control port
// Notes:   ramp and power timing counts derive from the 10 MHz core clock
package apv_pkg;
  localparam int          CLK_MHZ          = 10;
  localparam logic [5:0]  ADDR_MONO_RAMP   = 6'h04;
  localparam logic [5:0]  ADDR_POWER       = 6'h05;
  localparam logic [6:0]  GAIN_RESET       = 7'h67;
  localparam logic [6:0]  GAIN_MUTE_BELOW  = 7'h20;
  localparam logic [6:0]  GAIN_MAX         = 7'h7F;
  localparam logic [12:0] CTRL2_UPPER_DEF  = 13'h0000;
  localparam logic [15:0] POWER_RESET      = 16'hFF40;
  localparam int          BIT_MONO_SRC     = 2;
  localparam int          BIT_RAMP_RATE    = 1;
  localparam int          BIT_RAMP_DONE    = 0;
  localparam int          BIT_MASTER_PD    = 15;
  localparam int          BIT_REF_PD       = 14;
  localparam int          BIT_BYPASS_PD    = 13;
  localparam int          BIT_HP_PD        = 12;
  localparam int          BIT_MONO_PD      = 11;
  localparam int          BIT_DAC_PD       = 10;
  localparam int          BIT_ADCL_PD      = 9;
  localparam int          BIT_ADCR_PD      = 8;
  localparam int          BIT_SEQ_DONE     = 7;
  localparam int          BIT_MICB_PD      = 6;
  localparam int          BIT_OSC_EN       = 5;
  localparam int          BIT_CLKBUF_EN    = 4;
  localparam int          BIT_SYNC_PD      = 3;
  localparam int          BIT_SYNC_LOST    = 2;
  localparam int          STEP_FAST_US     = 20;
  localparam int          STEP_SLOW_US     = 40;
  localparam int          REF_UP_US        = 500;
  localparam int          STEP_FAST_CYC    = STEP_FAST_US * CLK_MHZ;
  localparam int          STEP_SLOW_CYC    = STEP_SLOW_US * CLK_MHZ;
  localparam int          REF_UP_CYC       = REF_UP_US * CLK_MHZ;
  localparam logic [12:0] STEP_FAST_CNT    = 13'(STEP_FAST_CYC - 1);
  localparam logic [12:0] STEP_SLOW_CNT    = 13'(STEP_SLOW_CYC - 1);
  localparam logic [12:0] REF_UP_CNT       = 13'(REF_UP_CYC - 1);
  localparam logic [12:0] CNT_ZERO         = 13'h0000;
  localparam logic [6:0]  GAIN_ONE         = 7'h01;
endpackage : apv_pkg

// ### core/apv_ctrl.sv
// Purpose: registers for mono routing, volume soft-step and audio power control
// Assumes: one register write or read per cycle from the serial control port
// Notes:   power outputs are active high power-on enables; all outputs are registered
//
// Summary of operation
// - right bypass gain is seven bits, half dB steps, 7Fh max, 67h unity
// - right bypass gain codes below 20h mute the right bypass path
// - right bypass gain resets to unity code 1100111
// - bit 2 picks mono source: 0 left ADC input, 1 headphone mix
// - bit 1 picks ramp step period: 0 about 20 us, 1 about 40 us
// - read-only bit 0 is 1 when all ramps finished, resets to 1
// - power bits 15 and 13 to 8: 1 powers section down, 0 powers it up
// - master powerdown bit 15 overrides all sections but a reference latched on with bit 14 clear, others keep values
// - bit 14 set: reference on only when needed; clear: stays on once started
// - reference power-up takes 500 us before dependent sections are ready
// - bits 13, 12, 10 power bypass, headphone amp, stereo DAC; reset 1
// - clearing mono driver bit powers line inputs, preamp, left mux, left volume
// - clearing left ADC bit powers left ADC and its front end
// - clearing right ADC bit powers right ADC and its front end
// - read-only bit 7 is 1 when all power sequences done, resets to 1
// - bit 6 clear enables mic bias; bias off after reset
// - bit 5 set turns crystal oscillator on; off after reset
// - bit 4 set enables oscillator clock buffer; off after reset
// - bit 3 switches the serial audio sync monitor on or off
// - sync monitor runs when bit 3 is 0, stopped when 1
// - bit 2 latches sync loss, clears when the register is read
`timescale 1ns/1ps
module apv_ctrl
  import apv_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // bypass gain source and events
  input  wire logic [6:0]  right_bypass_gain,
  input  wire logic        sync_error,
  // analog controls
  output logic [6:0]       bypass_gain_now,
  output logic             bypass_muted,
  output logic             mono_source_select,
  output logic             common_ref_on,
  output logic             bypass_on,
  output logic             headphone_on,
  output logic             mono_on,
  output logic             dac_on,
  output logic             adc_left_on,
  output logic             adc_right_on,
  output logic             left_front_on,
  output logic             right_front_on,
  output logic             mic_bias_on,
  output logic             osc_on,
  output logic             osc_clock_buffer_enable,
  output logic             sync_monitor_on
);
  ////////////////////////////////////////////////////////////////////////
  // state
  logic        ctrl_mono, ctrl_rate, next_mono, next_rate;
  logic [15:0] pwr, next_pwr;
  logic        sync_lost, next_sync_lost;
  logic [6:0]  gain_now, next_gain_now;
  logic [12:0] step_cnt, next_step_cnt;
  logic [12:0] ref_cnt, next_ref_cnt;
  logic        ref_up, next_ref_up;
  logic        ref_latched, next_ref_latched;
  logic [6:0]  want_sect, sect, next_sect;
  logic [15:0] next_rdata;
  logic        ramp_done, seq_done, ref_need, ref_want;
  logic        wr_ctrl, wr_pwr, rd_pwr;
  logic [6:0]  gain_tgt;

  assign wr_ctrl  = reg_wr && reg_addr == ADDR_MONO_RAMP;
  assign wr_pwr   = reg_wr && reg_addr == ADDR_POWER;
  assign rd_pwr   = reg_rd && reg_addr == ADDR_POWER;
  assign gain_tgt = right_bypass_gain;

  ////////////////////////////////////////////////////////////////////////
  // power demand
  always_comb begin
    // order: bypass, hp, mono, dac, adcl, adcr, micbias
    want_sect[0] = !pwr[BIT_BYPASS_PD];
    want_sect[1] = !pwr[BIT_HP_PD];
    want_sect[2] = !pwr[BIT_MONO_PD];
    want_sect[3] = !pwr[BIT_DAC_PD];
    want_sect[4] = !pwr[BIT_ADCL_PD];
    want_sect[5] = !pwr[BIT_ADCR_PD];
    want_sect[6] = !pwr[BIT_MICB_PD];
    if (pwr[BIT_MASTER_PD]) begin
      want_sect = '0;
    end
    ref_need = |want_sect[5:0];
    ref_want = pwr[BIT_REF_PD] ? ref_need : (ref_need || ref_latched);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_mono        = ctrl_mono;
    next_rate        = ctrl_rate;
    next_pwr         = pwr;
    next_gain_now    = gain_now;
    next_step_cnt    = step_cnt;
    next_ref_cnt     = ref_cnt;
    next_ref_up      = ref_up;
    next_ref_latched = ref_latched;
    next_sect        = sect;
    if (wr_ctrl) begin
      next_mono = reg_wdata[BIT_MONO_SRC];
      next_rate = reg_wdata[BIT_RAMP_RATE];
    end
    if (wr_pwr) begin
      next_pwr[15:BIT_SYNC_PD] = reg_wdata[15:BIT_SYNC_PD];
      next_pwr[BIT_SEQ_DONE]   = 1'b0;
    end
    // gain ramp, one half dB step per period
    if (gain_now == gain_tgt) begin
      next_step_cnt = CNT_ZERO;
    end else if (step_cnt == CNT_ZERO) begin
      next_step_cnt = ctrl_rate ? STEP_SLOW_CNT : STEP_FAST_CNT;
      next_gain_now = (gain_now < gain_tgt) ? gain_now + GAIN_ONE : gain_now - GAIN_ONE;
    end else begin
      next_step_cnt = step_cnt - 13'h0001;
    end
    // reference warm-up
    if (ref_need && !pwr[BIT_REF_PD]) begin
      next_ref_latched = 1'b1;
    end
    if (pwr[BIT_REF_PD] && !ref_need) begin
      next_ref_latched = 1'b0;
    end
    if (!ref_want) begin
      next_ref_up  = 1'b0;
      next_ref_cnt = REF_UP_CNT;
    end else if (!ref_up) begin
      if (ref_cnt == CNT_ZERO) begin
        next_ref_up = 1'b1;
      end else begin
        next_ref_cnt = ref_cnt - 13'h0001;
      end
    end
    // sections other than mic bias follow once reference ready; powerdown is immediate
    for (int i = 0; i < 7; i++) begin
      if (!want_sect[i]) begin
        next_sect[i] = 1'b0;
      end else if (ref_up || i == 6) begin
        next_sect[i] = 1'b1;
      end
    end
  end

  assign ramp_done = (gain_now == gain_tgt);
  assign seq_done  = (sect == want_sect) && (ref_up == ref_want);

  always_comb begin
    next_sync_lost = sync_lost;
    if (rd_pwr) begin
      next_sync_lost = 1'b0;
    end
    if (sync_error && !pwr[BIT_SYNC_PD]) begin
      next_sync_lost = 1'b1;
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd && reg_addr == ADDR_MONO_RAMP) begin
      next_rdata = {CTRL2_UPPER_DEF, ctrl_mono, ctrl_rate, ramp_done};
    end else if (rd_pwr) begin
      next_rdata                = pwr;
      next_rdata[BIT_SEQ_DONE]  = seq_done;
      next_rdata[BIT_SYNC_LOST] = sync_lost;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_mono   <= 1'b0;
      ctrl_rate   <= 1'b0;
      pwr         <= POWER_RESET;
      sync_lost   <= 1'b0;
      gain_now    <= GAIN_RESET;
      step_cnt    <= CNT_ZERO;
      ref_cnt     <= REF_UP_CNT;
      ref_up      <= 1'b0;
      ref_latched <= 1'b0;
      sect        <= '0;
      reg_rdata   <= 16'h0000;
    end else if (clk_en) begin
      ctrl_mono   <= next_mono;
      ctrl_rate   <= next_rate;
      pwr         <= next_pwr;
      sync_lost   <= next_sync_lost;
      gain_now    <= next_gain_now;
      step_cnt    <= next_step_cnt;
      ref_cnt     <= next_ref_cnt;
      ref_up      <= next_ref_up;
      ref_latched <= next_ref_latched;
      sect        <= next_sect;
      reg_rdata   <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bypass_gain_now         <= GAIN_RESET;
      bypass_muted            <= 1'b0;
      mono_source_select      <= 1'b0;
      common_ref_on           <= 1'b0;
      bypass_on               <= 1'b0;
      headphone_on            <= 1'b0;
      mono_on                 <= 1'b0;
      dac_on                  <= 1'b0;
      adc_left_on             <= 1'b0;
      adc_right_on            <= 1'b0;
      left_front_on           <= 1'b0;
      right_front_on          <= 1'b0;
      mic_bias_on             <= 1'b0;
      osc_on                  <= 1'b0;
      osc_clock_buffer_enable <= 1'b0;
      sync_monitor_on         <= 1'b1;
    end else if (clk_en) begin
      bypass_gain_now         <= next_gain_now;
      bypass_muted            <= next_gain_now < GAIN_MUTE_BELOW;
      mono_source_select      <= next_mono;
      common_ref_on           <= ref_want;
      bypass_on               <= next_sect[0];
      headphone_on            <= next_sect[1];
      mono_on                 <= next_sect[2];
      dac_on                  <= next_sect[3];
      adc_left_on             <= next_sect[4];
      adc_right_on            <= next_sect[5];
      left_front_on           <= next_sect[2] | next_sect[4];
      right_front_on          <= next_sect[5];
      mic_bias_on             <= next_sect[6];
      osc_on                  <= next_pwr[BIT_OSC_EN];
      osc_clock_buffer_enable <= next_pwr[BIT_CLKBUF_EN];
      sync_monitor_on         <= !next_pwr[BIT_SYNC_PD];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_master_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && pwr[BIT_MASTER_PD] |=> !bypass_on && !dac_on && !mono_on)
    else $error("section on under master powerdown");
  chk_mute_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    bypass_gain_now < GAIN_MUTE_BELOW |-> bypass_muted)
    else $error("low gain code not muted");
  chk_ref_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(ref_want) && clk_en |=> !ref_up [*8])
    else $error("reference ready too early");
  chk_sticky_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && sync_error && !pwr[BIT_SYNC_PD] |=> sync_lost)
    else $error("sync loss not latched");
  chk_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && rd_pwr && !sync_error |=> !sync_lost)
    else $error("sync loss not cleared by read");
  chk_osc_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_pwr |=> osc_on == $past(reg_wdata[BIT_OSC_EN]))
    else $error("oscillator enable mismatch");
  chk_mono_front: assert property (@(posedge core_clk) disable iff (!rst_n)
    mono_on |-> left_front_on)
    else $error("front end off with mono on");
  chk_ramp_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && gain_now != gain_tgt && step_cnt == CNT_ZERO |=> gain_now != $past(gain_now))
    else $error("ramp did not step");

  // warm-up length monitor
  logic [12:0] warm_cnt, next_warm_cnt;
  always_comb begin
    next_warm_cnt = CNT_ZERO;
    if (ref_want && !ref_up) begin
      next_warm_cnt = warm_cnt + 13'h0001;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_cnt <= CNT_ZERO;
    end else if (clk_en) begin
      warm_cnt <= next_warm_cnt;
    end
  end
  chk_ref_warm: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(ref_up) |-> warm_cnt == 13'(REF_UP_CYC))
    else $error("reference warm-up length wrong");
  chk_mono_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && wr_ctrl |=> mono_source_select == $past(reg_wdata[BIT_MONO_SRC]))
    else $error("mono source mismatch");
  chk_ramp_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == ADDR_MONO_RAMP && gain_now != gain_tgt |=> !reg_rdata[BIT_RAMP_DONE])
    else $error("ramp flag set during ramp");
  chk_adc_front: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!adc_left_on || left_front_on) && (!adc_right_on || right_front_on))
    else $error("front end off with adc on");
  chk_mute_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    bypass_gain_now >= GAIN_MUTE_BELOW |-> !bypass_muted)
    else $error("gain code muted in range");
  chk_mic_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !pwr[BIT_MASTER_PD] && !pwr[BIT_MICB_PD] |=> mic_bias_on)
    else $error("mic bias not on");
endmodule : apv_ctrl

// ### testbench/apv_ctrl_tb.sv
// Purpose: self-checking bench for the audio power and volume control block
// Assumes: read data one cycle after the strobe, outputs one cycle after a write
// Notes:   warm-up and ramp waits are bounded polls
`timescale 1ns/1ps
module apv_ctrl_tb
  import apv_pkg::*;
;
  logic        core_clk, rst_n, clk_en, reg_wr, reg_rd, sync_error;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [6:0]  right_bypass_gain, bypass_gain_now;
  logic        bypass_muted, mono_source_select, common_ref_on, bypass_on, headphone_on, mono_on;
  logic        dac_on, adc_left_on, adc_right_on, left_front_on, right_front_on, mic_bias_on;
  logic        osc_on, osc_clock_buffer_enable, sync_monitor_on;
  logic [11:0] misc;
  int          failures, cmp_count, cycles, n;

  assign misc = {osc_on, osc_clock_buffer_enable, sync_monitor_on, mic_bias_on, bypass_on, headphone_on,
                 mono_on, dac_on, adc_left_on, adc_right_on, left_front_on, right_front_on};

  apv_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .right_bypass_gain(right_bypass_gain),
    .sync_error(sync_error), .bypass_gain_now(bypass_gain_now), .bypass_muted(bypass_muted),
    .mono_source_select(mono_source_select), .common_ref_on(common_ref_on), .bypass_on(bypass_on),
    .headphone_on(headphone_on), .mono_on(mono_on), .dac_on(dac_on), .adc_left_on(adc_left_on),
    .adc_right_on(adc_right_on), .left_front_on(left_front_on), .right_front_on(right_front_on),
    .mic_bias_on(mic_bias_on), .osc_on(osc_on), .osc_clock_buffer_enable(osc_clock_buffer_enable),
    .sync_monitor_on(sync_monitor_on));

  always #50 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 100000) begin
      failures++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic wait_done();
    for (int i = 0; i < 4000; i++) begin
      rd(ADDR_POWER, v);
      if (v[BIT_SEQ_DONE] === 1'b1) break;
    end
    chk(16'(v[BIT_SEQ_DONE]), 16'h0001);
  endtask : wait_done

  task automatic pulse_sync();
    @(posedge core_clk);
    sync_error <= 1'b1;
    @(posedge core_clk);
    sync_error <= 1'b0;
  endtask : pulse_sync

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(ADDR_MONO_RAMP, v);
    chk(v, 16'h0001);
    rd(ADDR_POWER, v);
    chk(v, 16'hFFC0);
    chk(16'(bypass_gain_now), 16'h0067);
    chk(16'(misc), 16'h0200);
    rd(6'h3F, v);
    chk(v, 16'h0000);
  endtask : t_reset

  task automatic t_power();
    wr(ADDR_POWER, 16'h0000);
    @(posedge core_clk);
    #1;
    chk(16'(mic_bias_on), 16'h0001);
    repeat (4900) @(posedge core_clk);
    #1;
    chk(16'(misc[7:0]), 16'h0000);
    rd(ADDR_POWER, v);
    chk(v, 16'h0000);
    wait_done();
    chk(16'(misc[7:0]), 16'h00FF);
    wr(ADDR_POWER, 16'h8000);
    wait_done();
    chk(16'(misc[7:0]), 16'h0000);
    chk(v, 16'h8080);
    wr(ADDR_POWER, 16'h0000);
    wait_done();
    chk(16'(misc[7:0]), 16'h00FF);
    wr(ADDR_POWER, 16'h3F40);
    wait_done();
    chk(16'(common_ref_on), 16'h0001);
    wr(ADDR_POWER, 16'h7F40);
    wait_done();
    chk(16'(common_ref_on), 16'h0000);
  endtask : t_power

  task automatic t_front();
    logic [15:0] d [3];
    logic [11:0] e [3];
    d = '{16'h7778, 16'h7D40, 16'h7E40};
    e = '{12'hC22, 12'h20A, 12'h205};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_POWER, d[i]);
      wait_done();
      chk(16'(misc), 16'(e[i]));
    end
  endtask : t_front

  task automatic t_sync();
    wr(ADDR_POWER, 16'h7F48);
    wait_done();
    pulse_sync();
    rd(ADDR_POWER, v);
    chk(v, 16'h7FC8);
    wr(ADDR_POWER, 16'h7F47);
    wait_done();
    chk(v, 16'h7FC0);
    pulse_sync();
    rd(ADDR_POWER, v);
    chk(v, 16'h7FC4);
    rd(ADDR_POWER, v);
    chk(v, 16'h7FC0);
  endtask : t_sync

  task automatic t_ramp();
    wr(ADDR_MONO_RAMP, 16'h0004);
    rd(ADDR_MONO_RAMP, v);
    chk(v, 16'h0005);
    chk(16'(mono_source_select), 16'h0001);
    @(posedge core_clk);
    right_bypass_gain <= 7'h1F;
    rd(ADDR_MONO_RAMP, v);
    chk(v, 16'h0004);
    n = 0;
    while (bypass_gain_now !== 7'h1F && n < 20000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    #1;
    chk(16'(n >= 13700 && n <= 14300), 16'h0001);
    chk(16'(bypass_muted), 16'h0001);
    rd(ADDR_MONO_RAMP, v);
    chk(v, 16'h0005);
    wr(ADDR_MONO_RAMP, 16'h0002);
    chk(16'(mono_source_select), 16'h0000);
    @(posedge core_clk);
    right_bypass_gain <= 7'h22;
    n = 0;
    while (bypass_gain_now !== 7'h22 && n < 3000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    #1;
    chk(16'(n >= 780 && n <= 1250), 16'h0001);
    chk(16'(bypass_muted), 16'h0000);
  endtask : t_ramp

  task automatic t_freeze();
    @(posedge core_clk);
    clk_en    <= 1'b0;
    reg_addr  <= ADDR_MONO_RAMP;
    reg_wdata <= 16'h0000;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    clk_en    <= 1'b1;
    rd(ADDR_MONO_RAMP, v);
    chk(v, 16'h0003);
  endtask : t_freeze

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk          = 1'b0;
    rst_n             = 1'b0;
    clk_en            = 1'b1;
    reg_wr            = 1'b0;
    reg_rd            = 1'b0;
    sync_error        = 1'b0;
    reg_addr          = 6'h00;
    reg_wdata         = 16'h0000;
    right_bypass_gain = 7'h67;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_power();
    t_front();
    t_sync();
    t_ramp();
    t_freeze();
    conclude();
  end
endmodule : apv_ctrl_tb
